// ### inc/vcr_defines.vh
// Register offsets, field positions and constants of the configuration bank
`ifndef VCR_DEFINES_VH
`define VCR_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define VCR_IDX_CLK_DELAY 8'h43
`define VCR_IDX_CW_CFG 8'hc0
`define VCR_IDX_PH_1_4 8'hc1
`define VCR_IDX_PH_5_8 8'hc2
`define VCR_IDX_PH_9_12 8'hc3
`define VCR_IDX_PH_13_16 8'hc4
`define VCR_IDX_CH_PDN 8'hc5
`define VCR_IDX_BLK_PDN 8'hc6
`define VCR_IDX_FILTER 8'hc7
`define VCR_IDX_LOW_POW 8'hc8
`define VCR_IDX_CONS_CUR 8'hca
`define VCR_IDX_MED_POW 8'hce
`define VCR_IDX_SW_DIS 8'he6
`define VCR_IDX_GT_CTRL 8'hf0

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define VCR_DLY_MASK 16'h001e
`define VCR_CW_MASK 16'h001f
`define VCR_BLK_MASK 16'h000f
`define VCR_FILT_MASK 16'h0f80
`define VCR_LOWP_MASK 16'h1000
`define VCR_CONS_MASK 16'h0400
`define VCR_MEDP_MASK 16'h4000
`define VCR_SWD_MASK 16'h001f
`define VCR_GT_MASK 16'h0001
`define VCR_CW_SRATE_BIT 4
`define VCR_CW_X16_BIT 3
`define VCR_CW_RATIO_HI 2
`define VCR_CW_RATIO_LO 1
`define VCR_CW_SEL_BIT 0

// ----------------------------------------
// Reset value and analog constants
// ----------------------------------------
`define VCR_RESET_VAL 16'h0000
`define VCR_DLY_STEP_PS 110
`define VCR_CW_LNA_GAIN_DB 18
`define VCR_PHASE_STEP_MDEG 22500

`endif

// ### rtl/vcr_config_regs.v
// Configuration register bank with classic Wishbone slave port
//
// How it works
// - Bit clock delay taken from four-bit field at bits 4 to 1, 110 ps steps
// - Delay code is two's complement: 1111 means -110 ps, 0001 +110 ps
// - Every gain-section register holds zero after reset
// - Bit 4 selects single-rate clock input: 0 CMOS, 1 differential
// - Bit 3 selects sixteenfold clock input: 0 differential, 1 CMOS
// - Bits 2 to 1 give clock ratio: 16x, 8x, 4x, 1x
// - Bit 0 selects imaging or doppler path, never both at once
// - Doppler path forces amplifier gain 18 dB, disables attenuator and filter
// - Each four-bit phase word sets channel phase to N times 22.5 degrees
`timescale 1ns/1ps
`include "vcr_defines.vh"

module vcr_config_regs (
   // Clock and reset
   input wire CORE_CLK,
   input wire RESET,
   // Wishbone slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [9:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   output reg WB_ERR_O,
   // Output bit clock delay
   output reg signed [3:0] OUT_CLK_DELAY_CODE,
   output reg OUT_CLK_DELAY_LATE,
   output reg OUT_CLK_DELAY_EARLY,
   // Doppler clock set-up
   output reg SRATE_CLK_DIFF,
   output reg X16_CLK_DIFF,
   output reg [1:0] DOPPLER_CLOCK_RATIO,
   output reg DOPPLER_PATH_EN,
   output reg TIME_GAIN_PATH_EN,
   // Analog chain forcing
   output reg LNA_GAIN_FIXED_18DB,
   output reg ATTENUATOR_EN,
   output reg LPF_EN,
   // Mixer phase and power
   output reg [63:0] MIXER_PHASE_WORDS,
   output reg [15:0] CH_POWERDOWN,
   output reg [3:0] BLOCK_POWERDOWN,
   output reg [3:0] LNA_HPF_PROG,
   output reg LNA_HPF_DIS,
   output reg [1:0] LPF_PROG,
   output reg LOW_POWER,
   output reg CONST_CURRENT,
   output reg MEDIUM_POWER,
   output reg [4:0] SWITCH_DISABLE,
   output reg GAIN_TABLE_WRITE_ENABLE,
   output reg GAIN_MAP_WRITE_VIOLATION
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg [15:0] clk_delay_r;
   reg [15:0] cw_cfg_r;
   reg [15:0] phase_r [0:3];
   reg [15:0] ch_pdn_r;
   reg [15:0] blk_pdn_r;
   reg [15:0] filter_r;
   reg [15:0] low_pow_r;
   reg [15:0] cons_cur_r;
   reg [15:0] med_pow_r;
   reg [15:0] sw_dis_r;
   reg [15:0] gt_ctrl_r;
   reg violation_r;

   wire [7:0] idx = WB_ADR_I[9:2];
   wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
   wire wr = req & WB_WE_I;

   // Byte-lane merge, only defined bits stored
   function [15:0] merge;
      input [15:0] old_v;
      input [31:0] din;
      input [3:0] sel;
      input [15:0] mask;
      reg [15:0] m;
      begin
         m = old_v;
         if (sel[0]) begin
            m[7:0] = din[7:0];
         end
         if (sel[1]) begin
            m[15:8] = din[15:8];
         end
         merge = m & mask;
      end
   endfunction

   // Decode: 0 unmapped, 1 mapped, 2 mapped gain-section register
   function [1:0] decode;
      input [7:0] a;
      begin
         if (a == `VCR_IDX_CLK_DELAY || a == `VCR_IDX_GT_CTRL) begin
            decode = 2'h1;
         end else if ((a >= `VCR_IDX_CW_CFG && a <= `VCR_IDX_LOW_POW) ||
                      a == `VCR_IDX_CONS_CUR || a == `VCR_IDX_MED_POW ||
                      a == `VCR_IDX_SW_DIS) begin
            decode = 2'h2;
         end else begin
            decode = 2'h0;
         end
      end
   endfunction

   wire [1:0] dec = decode(idx);

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   reg [15:0] rd_nxt;
   always @* begin
      rd_nxt = 16'h0000;
      if (idx == `VCR_IDX_CLK_DELAY) begin
         rd_nxt = clk_delay_r;
      end else if (idx == `VCR_IDX_CW_CFG) begin
         rd_nxt = cw_cfg_r;
      end else if (idx >= `VCR_IDX_PH_1_4 && idx <= `VCR_IDX_PH_13_16) begin
         rd_nxt = phase_r[idx[1:0] - 2'h1];
      end else if (idx == `VCR_IDX_CH_PDN) begin
         rd_nxt = ch_pdn_r;
      end else if (idx == `VCR_IDX_BLK_PDN) begin
         rd_nxt = blk_pdn_r;
      end else if (idx == `VCR_IDX_FILTER) begin
         rd_nxt = filter_r;
      end else if (idx == `VCR_IDX_LOW_POW) begin
         rd_nxt = low_pow_r;
      end else if (idx == `VCR_IDX_CONS_CUR) begin
         rd_nxt = cons_cur_r;
      end else if (idx == `VCR_IDX_MED_POW) begin
         rd_nxt = med_pow_r;
      end else if (idx == `VCR_IDX_SW_DIS) begin
         rd_nxt = sw_dis_r;
      end else if (idx == `VCR_IDX_GT_CTRL) begin
         rd_nxt = {gt_ctrl_r[15:2], violation_r, gt_ctrl_r[0]};
      end
   end

   // ----------------------------------------
   // Bus handshake: ack, or err if unmapped, one cycle after request
   // ----------------------------------------
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         WB_ACK_O <= 1'b0;
         WB_ERR_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= req & (dec != 2'h0);
         WB_ERR_O <= req & (dec == 2'h0);
         WB_DAT_O <= (req & ~WB_WE_I) ? {16'h0000, rd_nxt} : 32'h00000000;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_phase
         always @(posedge CORE_CLK) begin
            if (RESET) begin
               phase_r[g] <= `VCR_RESET_VAL;
            end else if (wr && idx == `VCR_IDX_PH_1_4 + g) begin
               phase_r[g] <= merge(phase_r[g], WB_DAT_I, WB_SEL_I, 16'hffff);
            end
         end
      end
   endgenerate

   always @(posedge CORE_CLK) begin
      if (RESET) begin
         clk_delay_r <= `VCR_RESET_VAL;
         cw_cfg_r <= `VCR_RESET_VAL;
         ch_pdn_r <= `VCR_RESET_VAL;
         blk_pdn_r <= `VCR_RESET_VAL;
         filter_r <= `VCR_RESET_VAL;
         low_pow_r <= `VCR_RESET_VAL;
         cons_cur_r <= `VCR_RESET_VAL;
         med_pow_r <= `VCR_RESET_VAL;
         sw_dis_r <= `VCR_RESET_VAL;
         gt_ctrl_r <= `VCR_RESET_VAL;
         violation_r <= 1'b0;
      end else if (wr) begin
         // Unused bits dropped so a careless host cannot set them
         if (idx == `VCR_IDX_CLK_DELAY) begin
            clk_delay_r <= merge(clk_delay_r, WB_DAT_I, WB_SEL_I, `VCR_DLY_MASK);
         end else if (idx == `VCR_IDX_CW_CFG) begin
            cw_cfg_r <= merge(cw_cfg_r, WB_DAT_I, WB_SEL_I, `VCR_CW_MASK);
         end else if (idx == `VCR_IDX_CH_PDN) begin
            ch_pdn_r <= merge(ch_pdn_r, WB_DAT_I, WB_SEL_I, 16'hffff);
         end else if (idx == `VCR_IDX_BLK_PDN) begin
            blk_pdn_r <= merge(blk_pdn_r, WB_DAT_I, WB_SEL_I, `VCR_BLK_MASK);
         end else if (idx == `VCR_IDX_FILTER) begin
            filter_r <= merge(filter_r, WB_DAT_I, WB_SEL_I, `VCR_FILT_MASK);
         end else if (idx == `VCR_IDX_LOW_POW) begin
            low_pow_r <= merge(low_pow_r, WB_DAT_I, WB_SEL_I, `VCR_LOWP_MASK);
         end else if (idx == `VCR_IDX_CONS_CUR) begin
            cons_cur_r <= merge(cons_cur_r, WB_DAT_I, WB_SEL_I, `VCR_CONS_MASK);
         end else if (idx == `VCR_IDX_MED_POW) begin
            med_pow_r <= merge(med_pow_r, WB_DAT_I, WB_SEL_I, `VCR_MEDP_MASK);
         end else if (idx == `VCR_IDX_SW_DIS) begin
            sw_dis_r <= merge(sw_dis_r, WB_DAT_I, WB_SEL_I, `VCR_SWD_MASK);
         end else if (idx == `VCR_IDX_GT_CTRL) begin
            gt_ctrl_r <= merge(gt_ctrl_r, WB_DAT_I, WB_SEL_I, `VCR_GT_MASK);
            // Sticky flag cleared by writing 1 to bit 1, unless a new violation
            if (WB_SEL_I[0] && WB_DAT_I[1]) begin
               violation_r <= 1'b0;
            end
         end
         // Write still lands but is flagged; set wins over clear
         if (dec == 2'h2 && gt_ctrl_r[0]) begin
            violation_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Outputs, all registered
   // ----------------------------------------
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         OUT_CLK_DELAY_CODE <= 4'h0;
         OUT_CLK_DELAY_LATE <= 1'b0;
         OUT_CLK_DELAY_EARLY <= 1'b0;
         SRATE_CLK_DIFF <= 1'b0;
         X16_CLK_DIFF <= 1'b1;
         DOPPLER_CLOCK_RATIO <= 2'h0;
         DOPPLER_PATH_EN <= 1'b0;
         TIME_GAIN_PATH_EN <= 1'b1;
         LNA_GAIN_FIXED_18DB <= 1'b0;
         ATTENUATOR_EN <= 1'b1;
         LPF_EN <= 1'b1;
         MIXER_PHASE_WORDS <= 64'h0000000000000000;
         CH_POWERDOWN <= 16'h0000;
         BLOCK_POWERDOWN <= 4'h0;
         LNA_HPF_PROG <= 4'h0;
         LNA_HPF_DIS <= 1'b0;
         LPF_PROG <= 2'h0;
         LOW_POWER <= 1'b0;
         CONST_CURRENT <= 1'b0;
         MEDIUM_POWER <= 1'b0;
         SWITCH_DISABLE <= 5'h00;
         GAIN_TABLE_WRITE_ENABLE <= 1'b0;
         GAIN_MAP_WRITE_VIOLATION <= 1'b0;
      end else begin
         OUT_CLK_DELAY_CODE <= clk_delay_r[4:1];
         // Sign of the code picks direction; zero means neither
         OUT_CLK_DELAY_LATE <= ~clk_delay_r[4] & (clk_delay_r[3:1] != 3'h0);
         OUT_CLK_DELAY_EARLY <= clk_delay_r[4];
         SRATE_CLK_DIFF <= cw_cfg_r[`VCR_CW_SRATE_BIT];
         X16_CLK_DIFF <= ~cw_cfg_r[`VCR_CW_X16_BIT];
         DOPPLER_CLOCK_RATIO <= cw_cfg_r[`VCR_CW_RATIO_HI:`VCR_CW_RATIO_LO];
         // Both enables come from one bit, so never both active
         DOPPLER_PATH_EN <= cw_cfg_r[`VCR_CW_SEL_BIT];
         TIME_GAIN_PATH_EN <= ~cw_cfg_r[`VCR_CW_SEL_BIT];
         LNA_GAIN_FIXED_18DB <= cw_cfg_r[`VCR_CW_SEL_BIT];
         ATTENUATOR_EN <= ~cw_cfg_r[`VCR_CW_SEL_BIT];
         LPF_EN <= ~cw_cfg_r[`VCR_CW_SEL_BIT] & ~blk_pdn_r[3];
         MIXER_PHASE_WORDS <= {phase_r[3], phase_r[2], phase_r[1], phase_r[0]};
         CH_POWERDOWN <= ch_pdn_r;
         BLOCK_POWERDOWN <= blk_pdn_r[3:0];
         // Corner code is two bits wide; upper port bits held at zero
         LNA_HPF_PROG <= {2'h0, filter_r[11:10]};
         LNA_HPF_DIS <= filter_r[9];
         LPF_PROG <= filter_r[8:7];
         LOW_POWER <= low_pow_r[12];
         CONST_CURRENT <= cons_cur_r[10];
         MEDIUM_POWER <= med_pow_r[14];
         SWITCH_DISABLE <= sw_dis_r[4:0];
         GAIN_TABLE_WRITE_ENABLE <= gt_ctrl_r[0];
         GAIN_MAP_WRITE_VIOLATION <= violation_r;
      end
   end

endmodule

// ### sim/vcr_config_regs_properties.sv
// Port-level checks of the configuration bank
`timescale 1ns/1ps
`include "vcr_defines.vh"

module vcr_config_regs_properties (
   // Clock and reset
   input wire CORE_CLK,
   input wire RESET,
   // Bus
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [9:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   input wire [31:0] WB_DAT_O,
   input wire WB_ACK_O,
   input wire WB_ERR_O,
   // Derived levels
   input wire signed [3:0] OUT_CLK_DELAY_CODE,
   input wire OUT_CLK_DELAY_LATE,
   input wire OUT_CLK_DELAY_EARLY,
   input wire SRATE_CLK_DIFF,
   input wire X16_CLK_DIFF,
   input wire [1:0] DOPPLER_CLOCK_RATIO,
   input wire DOPPLER_PATH_EN,
   input wire TIME_GAIN_PATH_EN,
   input wire LNA_GAIN_FIXED_18DB,
   input wire ATTENUATOR_EN,
   input wire LPF_EN,
   input wire [15:0] CH_POWERDOWN
);
   // ----------------------------------------
   // Taken writes
   // ----------------------------------------
   wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
   wire tk = req && WB_WE_I && WB_SEL_I[0];
   wire tk_dly = tk && WB_ADR_I[9:2] == `VCR_IDX_CLK_DELAY;
   wire tk_cw = tk && WB_ADR_I[9:2] == `VCR_IDX_CW_CFG;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   AST_RESET_ZERO: assert property ($fell(RESET) |-> CH_POWERDOWN == 16'h0000 && X16_CLK_DIFF && DOPPLER_CLOCK_RATIO == 2'h0)
      else $error("levels not at reset values");
   AST_ANSWER: assert property (req |=> WB_ACK_O ^ WB_ERR_O)
      else $error("request not answered next cycle");
   AST_UPPER_ZERO: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   AST_DLY_WRITE: assert property (tk_dly |-> ##2 OUT_CLK_DELAY_CODE == $past(WB_DAT_I[4:1], 2))
      else $error("delay code not taken from bits 4 to 1");
   AST_DLY_SENSE: assert property (OUT_CLK_DELAY_LATE == (OUT_CLK_DELAY_CODE > 0) && OUT_CLK_DELAY_EARLY == OUT_CLK_DELAY_CODE[3])
      else $error("delay direction wrong");
   AST_CW_FIELDS: assert property (tk_cw |-> ##2 SRATE_CLK_DIFF == $past(WB_DAT_I[4], 2) && X16_CLK_DIFF != $past(WB_DAT_I[3], 2) && DOPPLER_CLOCK_RATIO == $past(WB_DAT_I[2:1], 2) && DOPPLER_PATH_EN == $past(WB_DAT_I[0], 2))
      else $error("cw config fields wrong");
   AST_PATH_ONE: assert property (DOPPLER_PATH_EN != TIME_GAIN_PATH_EN)
      else $error("both paths or none enabled");
   AST_CW_FORCE: assert property (DOPPLER_PATH_EN |-> LNA_GAIN_FIXED_18DB && !ATTENUATOR_EN && !LPF_EN)
      else $error("cw path forcing missing");
endmodule

bind vcr_config_regs vcr_config_regs_properties vcr_config_regs_properties_i (.*);

// ### sim/vcr_config_regs_tb_top.sv
// Self-checking bench of the configuration bank
`timescale 1ns/1ps

module vcr_config_regs_tb_top;
   // Nets keep the port names so the instance connects by name
   logic CORE_CLK = 1'b0, RESET = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
   logic [9:0] WB_ADR_I = 10'h000;
   logic [3:0] WB_SEL_I = 4'h0;
   logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q;
   logic signed [3:0] OUT_CLK_DELAY_CODE;
   logic [63:0] MIXER_PHASE_WORDS;
   logic [15:0] CH_POWERDOWN;
   logic [4:0] SWITCH_DISABLE;
   logic [3:0] BLOCK_POWERDOWN, LNA_HPF_PROG;
   logic [1:0] DOPPLER_CLOCK_RATIO, LPF_PROG;
   logic WB_ACK_O, WB_ERR_O, OUT_CLK_DELAY_LATE, OUT_CLK_DELAY_EARLY, SRATE_CLK_DIFF, e;
   logic X16_CLK_DIFF, DOPPLER_PATH_EN, TIME_GAIN_PATH_EN, LNA_GAIN_FIXED_18DB, ATTENUATOR_EN;
   logic LPF_EN, LNA_HPF_DIS, LOW_POWER, CONST_CURRENT, MEDIUM_POWER;
   logic GAIN_TABLE_WRITE_ENABLE, GAIN_MAP_WRITE_VIOLATION;
   int miscompares = 0, samples_checked = 0;

   vcr_config_regs vcr_config_regs_i (.*);

   always #4 CORE_CLK = ~CORE_CLK;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Classic cycle; waits for the answer under a bound
   task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] d);
      int n;
      @(posedge CORE_CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= {idx, 2'b00};
      WB_SEL_I <= 4'h3;
      WB_DAT_I <= {16'h0, d};
      n = 0;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1 && n < 50);
      q = WB_DAT_O;
      e = WB_ERR_O;
      if (n >= 50) miscompares++;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
   endtask

   task automatic close_out;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [7:0] r [13] = '{8'h43, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7,
         8'hc8, 8'hca, 8'hce, 8'he6};
      foreach (r[i]) begin
         wb(1'b0, r[i], 16'h0);
         check("reset read", q, 32'h0);
      end
      check("reset levels", {X16_CLK_DIFF, TIME_GAIN_PATH_EN, ATTENUATOR_EN, DOPPLER_PATH_EN}, 4'he);
      wb(1'b0, 8'hc9, 16'h0);
      check("unmapped", {e, q}, 33'h100000000);
      $display("reset test done");
   endtask

   task automatic t_delay;
      logic [3:0] c [5] = '{4'h0, 4'h1, 4'h2, 4'he, 4'hf};
      foreach (c[i]) begin
         wb(1'b1, 8'h43, {11'h0, c[i], 1'b0});
         repeat (2) @(posedge CORE_CLK);
         check("delay code", {OUT_CLK_DELAY_CODE}, c[i]);
         check("delay sense", {OUT_CLK_DELAY_LATE, OUT_CLK_DELAY_EARLY}, {c[i] != 4'h0 && !c[i][3], c[i][3]});
         wb(1'b0, 8'h43, 16'h0);
         check("delay read", q, {c[i], 1'b0});
      end
      $display("delay test done");
   endtask

   // Products of five cover every ratio, path and buffer mix
   task automatic t_cw;
      logic [4:0] v;
      for (int i = 0; i < 8; i++) begin
         v = 5'(i * 5);
         wb(1'b1, 8'hc0, {11'h0, v});
         repeat (2) @(posedge CORE_CLK);
         check("clock inputs", {SRATE_CLK_DIFF, X16_CLK_DIFF}, {v[4], !v[3]});
         check("clock ratio", DOPPLER_CLOCK_RATIO, v[2:1]);
         check("path", {DOPPLER_PATH_EN, TIME_GAIN_PATH_EN}, {v[0], !v[0]});
         check("cw forcing", {LNA_GAIN_FIXED_18DB, ATTENUATOR_EN, LPF_EN}, {v[0], {2{!v[0]}}});
         wb(1'b0, 8'hc0, 16'h0);
         check("cw read", q, v);
      end
      $display("cw test done");
   endtask

   task automatic t_phase;
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, 8'hc1 + k[7:0], 16'h3210 + 16'h4444 * k[15:0]);
      end
      repeat (2) @(posedge CORE_CLK);
      check("phase words", MIXER_PHASE_WORDS, 64'hfedcba9876543210);
      wb(1'b0, 8'hc3, 16'h0);
      check("phase read", q, 32'hba98);
      $display("phase test done");
   endtask

   // All-ones writes: only defined fields may stick
   task automatic t_misc;
      logic [7:0] a [7] = '{8'h43, 8'hc6, 8'hc7, 8'hc8, 8'hca, 8'hce, 8'he6};
      logic [15:0] m [7] = '{16'h001e, 16'h000f, 16'h0f80, 16'h1000, 16'h0400, 16'h4000,
         16'h001f};
      foreach (a[i]) begin
         wb(1'b1, a[i], 16'hffff);
         wb(1'b0, a[i], 16'h0);
         check("masked read", q, m[i]);
      end
      repeat (2) @(posedge CORE_CLK);
      check("block pdn", {BLOCK_POWERDOWN, LPF_EN}, 5'h1e);
      check("filter", {LNA_HPF_PROG, LNA_HPF_DIS, LPF_PROG}, 7'h1f);
      check("power", {LOW_POWER, CONST_CURRENT, MEDIUM_POWER, SWITCH_DISABLE}, 8'hff);
      $display("misc test done");
   endtask

   // Writing the map with the table enable set is flagged
   task automatic t_gate;
      wb(1'b1, 8'hf0, 16'h1);
      wb(1'b1, 8'hc5, 16'ha5c3);
      repeat (2) @(posedge CORE_CLK);
      check("gate flags", {GAIN_TABLE_WRITE_ENABLE, GAIN_MAP_WRITE_VIOLATION}, 2'h3);
      check("powerdown", CH_POWERDOWN, 16'ha5c3);
      wb(1'b1, 8'hf0, 16'h2);
      repeat (2) @(posedge CORE_CLK);
      check("gate clear", {GAIN_TABLE_WRITE_ENABLE, GAIN_MAP_WRITE_VIOLATION}, 2'h0);
      $display("gate test done");
   endtask

   initial begin
      repeat (8) @(posedge CORE_CLK);
      RESET <= 1'b0;
      t_reset;
      t_delay;
      t_cw;
      t_phase;
      t_misc;
      t_gate;
      close_out;
   end

   // Tests need well under a thousand cycles
   initial begin
      #100000;
      miscompares++;
      close_out;
   end
endmodule
